/* period_timer.sv */
// Top: 8-bit period timer with prescaler, postscaler and AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Postscale field bits 6..3 divides match pulses by field plus one.
// - Control bit 2 runs the timer; clear stops it holding count.
// - Control bit 7 ignores writes and reads zero.
// - Separate period register holds the terminal compare value.
// - Count increments per prescaled tick; at period, match pulse then wraps to zero.
// - Postscaler output sets sticky flag; it interrupts only when enabled.
// - Reset, count write and control write clear both scalers; control write keeps count.
// - Reset clears count and loads period with FFh.
module period_timer
  import period_timer_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // AXI4-Lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer outputs
  output logic periodMatchPulse,
  output logic irq
);
  scaler_if sc ();

  logic [7:0] timerControl;
  logic [7:0] timerPeriod;
  logic [7:0] timerCount;
  logic matchIrqFlag;
  logic matchIrqEnable;
  logic [1:0] instrDiv;
  logic countEn;
  logic awHeld;
  logic wHeld;
  logic [4:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // ==========================================================================
  // Instruction clock tick: one mclk in four
  assign sc.tick = clkEn && (instrDiv == 2'(INSTR_DIV - 1));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      instrDiv <= 2'h0;
    end else if (clkEn) begin
      instrDiv <= instrDiv + 2'h1;
    end
  end

  // ==========================================================================
  // Write channel: address and data taken in either order, then one response
  wire wrGo = awHeld && wHeld && !s_axi_bvalid;
  wire lane0 = wStrb[0];
  wire wrControl = wrGo && lane0 && (awAddr == {1'b0, OFF_CONTROL});
  wire wrPeriod = wrGo && lane0 && (awAddr == {1'b0, OFF_PERIOD});
  wire wrCount = wrGo && lane0 && (awAddr == {1'b0, OFF_COUNT});
  wire wrMask = wrGo && lane0 && (awAddr == OFF_IRQ_MASK);
  wire wrHit = (awAddr == {1'b0, OFF_CONTROL}) || (awAddr == {1'b0, OFF_PERIOD}) ||
    (awAddr == {1'b0, OFF_COUNT}) || (awAddr == {1'b0, OFF_IRQ_STATUS}) ||
    (awAddr == OFF_IRQ_MASK);
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      awAddr <= 5'h00;
    end else if (s_axi_awvalid && !awHeld) begin
      awHeld <= 1'b1;
      awAddr <= {s_axi_awaddr[4:2], 2'h0};
    end else if (wrGo) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (wrGo) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrGo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Registers written by software; the bus is never frozen by clkEn
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timerControl <= RST_CONTROL;
      timerPeriod <= RST_PERIOD;
      matchIrqEnable <= 1'b0;
    end else begin
      if (wrControl) begin
        timerControl <= wData[7:0] & CTL_WRITE_MASK;
      end
      if (wrPeriod) begin
        timerPeriod <= wData[7:0];
      end
      if (wrMask) begin
        matchIrqEnable <= wData[0];
      end
    end
  end

  // ==========================================================================
  // Counter
  assign sc.preSel = timerControl[CTL_PRE_LSB +: 2];
  assign sc.postSel = timerControl[CTL_POST_LSB +: 4];
  assign sc.clear = wrCount || wrControl;
  wire timerRun = timerControl[CTL_RUN_BIT];
  wire atPeriod = (timerCount == timerPeriod);
  // A scaler clear restarts the prescaled clock, so no step in that cycle
  wire stepNow = clkEn && timerRun && countEn && !sc.clear;
  assign sc.match = stepNow && atPeriod;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timerCount <= RST_COUNT;
    end else if (wrCount) begin
      timerCount <= wData[7:0];
    end else if (stepNow) begin
      timerCount <= atPeriod ? 8'h00 : timerCount + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      periodMatchPulse <= 1'b0;
    end else if (clkEn) begin
      periodMatchPulse <= sc.match;
    end
  end

  scaler_chain u_scaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .sc(sc),
    .countEn(countEn)
  );

  // ==========================================================================
  // Read channel and interrupt flag
  logic [4:0] arAddr;
  assign arAddr = {s_axi_araddr[4:2], 2'h0};
  assign s_axi_arready = !s_axi_rvalid;
  wire rdGo = s_axi_arvalid && !s_axi_rvalid;
  wire rdStatus = rdGo && (arAddr == {1'b0, OFF_IRQ_STATUS});
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (arAddr == {1'b0, OFF_CONTROL}) begin
      rdMux = {24'h000000, timerControl};
    end else if (arAddr == {1'b0, OFF_PERIOD}) begin
      rdMux = {24'h000000, timerPeriod};
    end else if (arAddr == {1'b0, OFF_COUNT}) begin
      rdMux = {24'h000000, timerCount};
    end else if (arAddr == {1'b0, OFF_IRQ_STATUS}) begin
      rdMux = {31'h0000_0000, matchIrqFlag};
    end else if (arAddr == OFF_IRQ_MASK) begin
      rdMux = {31'h0000_0000, matchIrqEnable};
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdGo) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Set wins over the clear-on-read so a late match is never lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      matchIrqFlag <= 1'b0;
    end else if (clkEn && sc.postOut) begin
      matchIrqFlag <= 1'b1;
    end else if (rdStatus) begin
      matchIrqFlag <= 1'b0;
    end
  end

  assign irq = matchIrqFlag && matchIrqEnable;

  // ==========================================================================
  // Checks
  property p_run_hold;
    @(posedge mclk) disable iff (sys_rst)
      (!timerRun && !wrCount) |=> (timerCount == $past(timerCount));
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

  property p_bit7_zero;
    @(posedge mclk) disable iff (sys_rst)
      wrControl |=> (timerControl[7] == 1'b0);
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 set");

  property p_period_wr;
    @(posedge mclk) disable iff (sys_rst)
      wrPeriod |=> (timerPeriod == $past(wData[7:0]));
  endproperty
  a_period_wr: assert property (p_period_wr) else $error("period not written");

  property p_wrap;
    @(posedge mclk) disable iff (sys_rst)
      (sc.match && !wrCount) |=> (timerCount == 8'h00) && periodMatchPulse;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap on match");

  property p_flag_set;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && sc.postOut) |=> matchIrqFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq_gate;
    @(posedge mclk) disable iff (sys_rst)
      irq |-> matchIrqEnable && matchIrqFlag;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_ctl_keeps_count;
    @(posedge mclk) disable iff (sys_rst)
      (wrControl && !wrCount) |=> (timerCount == $past(timerCount));
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("count hit");

  property p_reset_vals;
    @(posedge mclk) sys_rst |=> (timerCount == 8'h00) && (timerPeriod == 8'hFF);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_step_inc;
    @(posedge mclk) disable iff (sys_rst)
      (stepNow && !atPeriod && !wrCount) |=> (timerCount == $past(timerCount) + 8'h01);
  endproperty
  a_step_inc: assert property (p_step_inc) else $error("count did not step");

  property p_flag_hold;
    @(posedge mclk) disable iff (sys_rst)
      (matchIrqFlag && !rdStatus) |=> matchIrqFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without read");

  property p_read_clears;
    @(posedge mclk) disable iff (sys_rst)
      (rdStatus && !(clkEn && sc.postOut)) |=> !matchIrqFlag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag kept after read");

  c_match: cover property (@(posedge mclk) disable iff (sys_rst) sc.match);
  c_irq: cover property (@(posedge mclk) disable iff (sys_rst) irq);
  c_ctl_running: cover property (@(posedge mclk) disable iff (sys_rst) wrControl && timerRun);
  c_set_and_read: cover property (@(posedge mclk) disable iff (sys_rst)
    sc.postOut && rdStatus);
endmodule

/* period_timer_pkg.sv */
// Package: register map, field layout, reset values and timing for the period timer
package period_timer_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_PERIOD = 4'h4;
  localparam logic [3:0] OFF_COUNT = 4'h8;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'hC;
  // Mask register sits past the first nibble of the map
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  // ==========================================================================
  // Control field positions
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;
  // ==========================================================================
  // Timing: instruction clock is the system clock divided by four
  localparam int INSTR_DIV = 4;
  // Prescale terminal counts (divide minus one) for codes 00..11
  localparam logic [5:0] PRE_TC_1 = 6'h00;
  localparam logic [5:0] PRE_TC_4 = 6'h03;
  localparam logic [5:0] PRE_TC_16 = 6'h0F;
  localparam logic [5:0] PRE_TC_64 = 6'h3F;
  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* period_timer_tb_top.sv */
// Self-checking testbench for the period timer
`timescale 1ns/1ps
module period_timer_tb_top
  import period_timer_pkg::*;
;
  // ==========================================================================
  // Stimulus and observation signals
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic [4:0] awAddr = 5'h00;
  logic awValid = 1'b0;
  logic awReady;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic wValid = 1'b0;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic bReady = 1'b0;
  logic [4:0] arAddr = 5'h00;
  logic arValid = 1'b0;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic rReady = 1'b0;
  logic periodMatchPulse;
  logic irq;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Expected answers, oldest first
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  always #5 mclk = ~mclk;

  period_timer dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .periodMatchPulse(periodMatchPulse), .irq(irq));

  // ==========================================================================
  // Checking and closing
  task check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("Counts: %0d compares, %0d miscompares", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the longest pass of the sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  // Responses are compared at the handshake edge against the oldest note
  always @(posedge mclk) begin
    if (rValid === 1'b1 && rReady === 1'b1) begin
      check({rResp, rData}, rq.pop_front());
    end
    if (bValid === 1'b1 && bReady === 1'b1) begin
      check({32'h0, bResp}, {32'h0, bq.pop_front()});
    end
  end

  // ==========================================================================
  // Bus master tasks
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    bq.push_back(er);
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= {24'h0, d};
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge mclk);
      if (!aw && awReady === 1'b1) begin
        aw = 1'b1;
        awValid <= 1'b0;
      end
      if (!w && wReady === 1'b1) begin
        w = 1'b1;
        wValid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge mclk); while (bValid !== 1'b1);
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    rq.push_back({er, 24'h0, d});
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge mclk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge mclk); while (rValid !== 1'b1);
    rReady <= 1'b0;
  endtask

  // Cycles between two successive match pulses
  task automatic gap(output int n);
    do @(posedge mclk); while (periodMatchPulse !== 1'b1);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (periodMatchPulse !== 1'b1);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    logic [7:0] p;
    logic [7:0] r;
    void'($urandom(17));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(5'(OFF_CONTROL), RST_CONTROL, RESP_OKAY);
    rd(5'(OFF_PERIOD), RST_PERIOD, RESP_OKAY);
    rd(5'(OFF_COUNT), RST_COUNT, RESP_OKAY);
    rd(5'(OFF_IRQ_STATUS), 8'h00, RESP_OKAY);
    rd(OFF_IRQ_MASK, 8'h00, RESP_OKAY);
    wr(5'(OFF_CONTROL), 8'hF8, RESP_OKAY);
    rd(5'(OFF_CONTROL), 8'h78, RESP_OKAY);
    wr(5'h14, 8'h5A, RESP_SLVERR);
    rd(5'h1C, 8'h00, RESP_SLVERR);
    p = 8'($urandom());
    r = 8'($urandom());
    wr(5'(OFF_PERIOD), p, RESP_OKAY);
    rd(5'(OFF_PERIOD), p, RESP_OKAY);
    // Lane 0 strobe low: write is answered but must not land
    wStrb <= 4'hE;
    wr(5'(OFF_PERIOD), ~p, RESP_OKAY);
    wStrb <= 4'hF;
    rd(5'(OFF_PERIOD), p, RESP_OKAY);
    wr(5'(OFF_COUNT), r, RESP_OKAY);
    // Frozen clock enable: running timer must not step
    clkEn <= 1'b0;
    wr(5'(OFF_CONTROL), 8'h04, RESP_OKAY);
    repeat (40) @(posedge mclk);
    rd(5'(OFF_COUNT), r, RESP_OKAY);
    wr(5'(OFF_CONTROL), 8'h00, RESP_OKAY);
    clkEn <= 1'b1;
    repeat (40) @(posedge mclk);
    rd(5'(OFF_COUNT), r, RESP_OKAY);
    wr(5'(OFF_CONTROL), 8'h03, RESP_OKAY);
    rd(5'(OFF_COUNT), r, RESP_OKAY);
    // Match interval is four prescaled steps per match, period 3
    wr(5'(OFF_PERIOD), 8'h03, RESP_OKAY);
    wr(5'(OFF_COUNT), 8'h00, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(5'(OFF_CONTROL), 8'(4 + c), RESP_OKAY);
      gap(n);
      check(34'(n), 34'(16 << (2 * c)));
    end
    check(34'(irq), 34'h0);
    wr(5'(OFF_CONTROL), 8'h00, RESP_OKAY);
    rd(5'(OFF_IRQ_STATUS), 8'h01, RESP_OKAY);
    rd(5'(OFF_IRQ_STATUS), 8'h00, RESP_OKAY);
    wr(OFF_IRQ_MASK, 8'h01, RESP_OKAY);
    for (int post = 0; post < 16; post++) begin
      wr(5'(OFF_COUNT), 8'h00, RESP_OKAY);
      wr(5'(OFF_CONTROL), {1'b0, 4'(post), 3'b100}, RESP_OKAY);
      n = 0;
      do begin
        @(posedge mclk);
        if (periodMatchPulse === 1'b1) n++;
      end while (irq !== 1'b1);
      check(34'(n), 34'(post + 1));
      wr(5'(OFF_CONTROL), 8'h00, RESP_OKAY);
      rd(5'(OFF_IRQ_STATUS), 8'h01, RESP_OKAY);
    end
    @(posedge mclk);
    check(34'(irq), 34'h0);
    close_out();
  end
endmodule

/* scaler_chain.sv */
// Prescaler gate and postscaler counter for the period timer
`timescale 1ns/1ps
module scaler_chain
  import period_timer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Control
  scaler_if.core sc,
  // Gated count enable
  output logic countEn
);
  logic [5:0] preCnt;
  logic [3:0] postCnt;
  logic [5:0] preTc;
  logic preWrap;
  logic postWrap;

  assign preTc = (sc.preSel == 2'h0) ? PRE_TC_1 :
                 (sc.preSel == 2'h1) ? PRE_TC_4 :
                 (sc.preSel == 2'h2) ? PRE_TC_16 : PRE_TC_64;
  assign preWrap = (preCnt >= preTc);
  assign countEn = sc.tick && preWrap;
  assign postWrap = (postCnt >= sc.postSel);
  assign sc.postOut = sc.match && postWrap;

  // Clears land even while frozen, because register writes still go through
  always_ff @(posedge mclk) begin
    if (sys_rst || sc.clear) begin
      preCnt <= 6'h00;
    end else if (clkEn && sc.tick) begin
      preCnt <= preWrap ? 6'h00 : preCnt + 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || sc.clear) begin
      postCnt <= 4'h0;
    end else if (clkEn && sc.match) begin
      postCnt <= postWrap ? 4'h0 : postCnt + 4'h1;
    end
  end

  // ==========================================================================
  // Checks
  property p_post_div;
    @(posedge mclk) disable iff (sys_rst)
      (clkEn && sc.postOut && !sc.clear) |=> (postCnt == 4'h0);
  endproperty
  a_post_div: assert property (p_post_div) else $error("postscaler did not wrap");
  property p_pre_gate;
    @(posedge mclk) disable iff (sys_rst)
      countEn |-> (preCnt == preTc);
  endproperty
  a_pre_gate: assert property (p_pre_gate) else $error("count enable off prescale");
endmodule

/* scaler_if.sv */
// Interface: control between register block and the scaler chain
`timescale 1ns/1ps
interface scaler_if;
  logic tick;
  logic clear;
  logic [1:0] preSel;
  logic [3:0] postSel;
  logic match;
  logic postOut;
  modport core (input tick, input clear, input preSel, input postSel, input match,
    output postOut);
  modport ctl (output tick, output clear, output preSel, output postSel, output match,
    input postOut);
endinterface
